/* File: hw/aarres_pkg.sv */
// Address resolver constants and types
package aarres_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_BEGIN_TRIGGER = 12'h000;
    localparam logic [11:0] OFF_HALT_TRIGGER = 12'h008;
    localparam logic [11:0] OFF_EVENT_DONE = 12'h100;
    localparam logic [11:0] OFF_EVENT_MATCH = 12'h104;
    localparam logic [11:0] OFF_EVENT_NO_MATCH = 12'h108;
    localparam logic [11:0] OFF_INTERRUPT_SET = 12'h304;
    localparam logic [11:0] OFF_INTERRUPT_DISABLE = 12'h308;
    localparam logic [11:0] OFF_STATUS = 12'h400;
    localparam logic [11:0] OFF_UNIT_ENABLE = 12'h500;
    localparam logic [11:0] OFF_KEY_COUNT = 12'h504;
    localparam logic [11:0] OFF_KEY_TABLE_POINTER = 12'h508;
    localparam logic [11:0] OFF_TARGET_ADDRESS_POINTER = 12'h510;
    localparam logic [11:0] OFF_SCRATCH_AREA_POINTER = 12'h514;

    // Interrupt bits of set and disable
    localparam int BIT_DONE = 0;
    localparam int BIT_MATCH = 1;
    localparam int BIT_NO_MATCH = 2;

    // Field values and reset values
    localparam logic [1:0] UNIT_ENABLE_OFF = 2'h0;
    localparam logic [1:0] UNIT_ENABLE_ON = 2'h3;
    localparam logic [4:0] KEY_COUNT_RESET = 5'h01;
    localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
    localparam logic [31:0] POINTER_RESET = 32'h00000000;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // Memory layout: a key is four words, the address two words
    localparam logic [1:0] KEY_WORDS_LAST = 2'h3;
    localparam logic [31:0] KEY_STRIDE = 32'h00000010;
    localparam logic [31:0] WORD_STRIDE = 32'h00000004;

    // Timing: fixed overhead plus one slot per key checked
    localparam int CLK_MHZ = 200;
    localparam int OVERHEAD_NS = 1000;
    localparam int PER_KEY_NS = 5875;
    localparam int OVERHEAD_CYCLES = (OVERHEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int PER_KEY_CYCLES = (PER_KEY_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMER_W = 12;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } aarres_mem_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } aarres_mem_rsp_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR_LO = 6'b000010,
        ST_ADDR_HI = 6'b000100,
        ST_OVERHEAD = 6'b001000,
        ST_KEY_FETCH = 6'b010000,
        ST_KEY_WAIT = 6'b100000
    } aarres_state_t;
endpackage : aarres_pkg

/* File: hw/aarres_top.sv */
// Address resolver: Wishbone registers, key walker, interrupts
//
// Function
// [RULE_01] Writing one to interrupt_disable turns that interrupt off; reads show the enables.
// [RULE_02] status reads the index of the key behind the latest match.
// [RULE_03] unit_enable is off at 0 and on at 3, and resets to off.
// [RULE_04] key_count holds 1..16 keys and resets to 1.
// [RULE_05] Keys are fetched from key_table_pointer.
// [RULE_06] The target address is read from target_address_pointer.
// [RULE_07] Software points scratch_area_pointer at three or more bytes.
// [RULE_08] Resolution takes a fixed overhead plus one time slot per key checked.
// [RULE_09] The begin trigger starts resolution and the halt trigger stops it.
// [RULE_10] At the end done rises with either match or no_match, each reading 1.
// [RULE_11] Writing one to interrupt_set enables that interrupt.
// [RULE_12] Keys are tested in order and the first match ends the walk.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aarres_top #(
    parameter int MAX_KEYS = 16
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [11:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic IRQ_OUT,
    output aarres_pkg::aarres_mem_req_t MEM_REQ_OUT,
    input wire aarres_pkg::aarres_mem_rsp_t MEM_RSP_IN
);
    initial begin
        if (MAX_KEYS != 16) begin
            $error("MAX_KEYS must be 16");
        end
    end

    // Stand-in for the block cipher
    function automatic logic [23:0] fold24(input logic [31:0] w, input logic [23:0] acc);
        fold24 = {acc[22:0], acc[23]} ^ w[23:0] ^ {16'h0000, w[31:24]};
    endfunction : fold24

    function automatic logic hit(input logic [11:0] adr, input logic [11:0] off);
        hit = (adr[11:2] == off[11:2]);
    endfunction : hit

    // Register state
    logic ack;
    logic [31:0] rdata;
    logic [2:0] event_flag;
    logic [2:0] int_mask;
    logic [3:0] status;
    logic [1:0] unit_enable;
    logic [4:0] key_count;
    logic [31:0] key_table_pointer;
    logic [31:0] target_address_pointer;
    logic [31:0] scratch_area_pointer;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [2:0] next_event_flag;
    logic [2:0] next_int_mask;
    logic [3:0] next_status;
    logic [1:0] next_unit_enable;
    logic [4:0] next_key_count;
    logic [31:0] next_key_table_pointer;
    logic [31:0] next_target_address_pointer;
    logic [31:0] next_scratch_area_pointer;

    localparam int TIMER_W_L = aarres_pkg::TIMER_W;
    localparam logic [TIMER_W_L-1:0] OVERHEAD_LOAD = TIMER_W_L'(aarres_pkg::OVERHEAD_CYCLES - 1);
    localparam logic [TIMER_W_L-1:0] PER_KEY_LOAD = TIMER_W_L'(aarres_pkg::PER_KEY_CYCLES - 1);

    // Resolver state
    aarres_pkg::aarres_state_t state;
    aarres_pkg::aarres_state_t next_state;
    logic [TIMER_W_L-1:0] timer;
    logic [TIMER_W_L-1:0] next_timer;
    logic [1:0] word_cnt;
    logic [1:0] next_word_cnt;
    logic [3:0] key_idx;
    logic [3:0] next_key_idx;
    logic [23:0] target_hash;
    logic [23:0] next_target_hash;
    logic [23:0] prand;
    logic [23:0] next_prand;
    logic [23:0] key_acc;
    logic [23:0] next_key_acc;
    logic [31:0] mem_addr;
    logic [31:0] next_mem_addr;
    logic mem_req;
    logic next_mem_req;

    // Bus decode and resolver handshakes
    logic wr;
    logic begin_trigger;
    logic halt_trigger;
    logic done_pulse;
    logic match_pulse;
    logic no_match_pulse;
    logic [3:0] keys_last;

    always_comb begin
        wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !ack && WB_SEL_IN[0];
        begin_trigger = wr && hit(WB_ADR_IN, aarres_pkg::OFF_BEGIN_TRIGGER) && WB_DAT_IN[0];
        halt_trigger = wr && hit(WB_ADR_IN, aarres_pkg::OFF_HALT_TRIGGER) && WB_DAT_IN[0];
        // Out-of-range counts are clamped so the walk always ends
        if (key_count == 5'h00) begin
            keys_last = 4'h0;
        end else if (key_count > aarres_pkg::KEY_COUNT_MAX) begin
            keys_last = 4'hf;
        end else begin
            keys_last = 4'(key_count - 5'h01); // [RULE_04]
        end
    end

    // Resolver next state
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_word_cnt = word_cnt;
        next_key_idx = key_idx;
        next_target_hash = target_hash;
        next_prand = prand;
        next_key_acc = key_acc;
        next_mem_addr = mem_addr;
        next_mem_req = mem_req;
        done_pulse = 1'b0;
        match_pulse = 1'b0;
        no_match_pulse = 1'b0;
        if (timer != '0) begin
            next_timer = timer - 1'b1;
        end
        case (state)
            aarres_pkg::ST_IDLE: begin
                if (begin_trigger && unit_enable == aarres_pkg::UNIT_ENABLE_ON) begin // [RULE_03] [RULE_09]
                    next_state = aarres_pkg::ST_ADDR_LO;
                    next_mem_addr = target_address_pointer; // [RULE_06]
                    next_mem_req = 1'b1;
                    next_timer = OVERHEAD_LOAD; // [RULE_08]
                    next_key_idx = 4'h0;
                end
            end
            aarres_pkg::ST_ADDR_LO: begin
                if (MEM_RSP_IN.ack) begin
                    next_target_hash = MEM_RSP_IN.rdata[23:0];
                    next_prand[7:0] = MEM_RSP_IN.rdata[31:24];
                    next_mem_addr = mem_addr + aarres_pkg::WORD_STRIDE;
                    next_state = aarres_pkg::ST_ADDR_HI;
                end
            end
            aarres_pkg::ST_ADDR_HI: begin
                if (MEM_RSP_IN.ack) begin
                    next_prand[23:8] = MEM_RSP_IN.rdata[15:0];
                    next_mem_addr = mem_addr + aarres_pkg::WORD_STRIDE;
                    next_mem_req = 1'b0;
                    next_state = aarres_pkg::ST_OVERHEAD;
                end
            end
            aarres_pkg::ST_OVERHEAD: begin
                if (timer == '0) begin
                    next_state = aarres_pkg::ST_KEY_FETCH;
                    next_mem_addr = key_table_pointer; // [RULE_05]
                    next_mem_req = 1'b1;
                    next_word_cnt = 2'h0;
                    next_key_acc = prand;
                    next_timer = PER_KEY_LOAD; // [RULE_08]
                end
            end
            aarres_pkg::ST_KEY_FETCH: begin
                if (MEM_RSP_IN.ack) begin
                    next_key_acc = fold24(MEM_RSP_IN.rdata, key_acc);
                    next_mem_addr = mem_addr + aarres_pkg::WORD_STRIDE;
                    next_word_cnt = word_cnt + 2'h1;
                    if (word_cnt == aarres_pkg::KEY_WORDS_LAST) begin
                        next_mem_req = 1'b0;
                        next_state = aarres_pkg::ST_KEY_WAIT;
                    end
                end
            end
            aarres_pkg::ST_KEY_WAIT: begin
                // Each key occupies a whole time slot, so total time grows linearly
                if (timer == '0) begin
                    if (key_acc == target_hash) begin // [RULE_12]
                        match_pulse = 1'b1;
                        done_pulse = 1'b1;
                        next_state = aarres_pkg::ST_IDLE;
                    end else if (key_idx == keys_last) begin
                        no_match_pulse = 1'b1;
                        done_pulse = 1'b1;
                        next_state = aarres_pkg::ST_IDLE;
                    end else begin
                        next_key_idx = key_idx + 4'h1;
                        next_word_cnt = 2'h0;
                        next_key_acc = prand;
                        next_mem_req = 1'b1;
                        next_timer = PER_KEY_LOAD; // [RULE_08]
                        next_state = aarres_pkg::ST_KEY_FETCH;
                    end
                end
            end
            default: begin
                next_state = aarres_pkg::ST_IDLE;
                next_mem_req = 1'b0;
            end
        endcase
        // Halt, or disabling the unit, abandons a walk without raising events
        if (state != aarres_pkg::ST_IDLE && (halt_trigger || unit_enable != aarres_pkg::UNIT_ENABLE_ON)) begin // [RULE_09]
            next_state = aarres_pkg::ST_IDLE;
            next_mem_req = 1'b0;
            next_timer = '0;
            done_pulse = 1'b0;
            match_pulse = 1'b0;
            no_match_pulse = 1'b0;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= aarres_pkg::ST_IDLE;
            timer <= '0;
            word_cnt <= 2'h0;
            key_idx <= 4'h0;
            target_hash <= 24'h000000;
            prand <= 24'h000000;
            key_acc <= 24'h000000;
            mem_addr <= 32'h00000000;
            mem_req <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            word_cnt <= next_word_cnt;
            key_idx <= next_key_idx;
            target_hash <= next_target_hash;
            prand <= next_prand;
            key_acc <= next_key_acc;
            mem_addr <= next_mem_addr;
            mem_req <= next_mem_req;
        end
    end

    // Register file next state
    always_comb begin
        next_ack = WB_CYC_IN && WB_STB_IN && !ack;
        next_rdata = 32'h00000000;
        next_event_flag = event_flag;
        next_int_mask = int_mask;
        next_status = status;
        next_unit_enable = unit_enable;
        next_key_count = key_count;
        next_key_table_pointer = key_table_pointer;
        next_target_address_pointer = target_address_pointer;
        next_scratch_area_pointer = scratch_area_pointer;
        if (WB_CYC_IN && WB_STB_IN && !ack && !WB_WE_IN) begin
            case (WB_ADR_IN[11:2])
                aarres_pkg::OFF_EVENT_DONE[11:2]: next_rdata = {31'h0, event_flag[aarres_pkg::BIT_DONE]};
                aarres_pkg::OFF_EVENT_MATCH[11:2]: next_rdata = {31'h0, event_flag[aarres_pkg::BIT_MATCH]};
                aarres_pkg::OFF_EVENT_NO_MATCH[11:2]: next_rdata = {31'h0, event_flag[aarres_pkg::BIT_NO_MATCH]};
                aarres_pkg::OFF_INTERRUPT_SET[11:2]: next_rdata = {29'h0, int_mask};
                aarres_pkg::OFF_INTERRUPT_DISABLE[11:2]: next_rdata = {29'h0, int_mask}; // [RULE_01]
                aarres_pkg::OFF_STATUS[11:2]: next_rdata = {28'h0, status}; // [RULE_02]
                aarres_pkg::OFF_UNIT_ENABLE[11:2]: next_rdata = {30'h0, unit_enable};
                aarres_pkg::OFF_KEY_COUNT[11:2]: next_rdata = {27'h0, key_count};
                aarres_pkg::OFF_KEY_TABLE_POINTER[11:2]: next_rdata = key_table_pointer;
                aarres_pkg::OFF_TARGET_ADDRESS_POINTER[11:2]: next_rdata = target_address_pointer;
                aarres_pkg::OFF_SCRATCH_AREA_POINTER[11:2]: next_rdata = scratch_area_pointer;
                default: next_rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (WB_ADR_IN[11:2])
                aarres_pkg::OFF_EVENT_DONE[11:2]: begin
                    if (WB_DAT_IN[0]) next_event_flag[aarres_pkg::BIT_DONE] = 1'b0;
                end
                aarres_pkg::OFF_EVENT_MATCH[11:2]: begin
                    if (WB_DAT_IN[0]) next_event_flag[aarres_pkg::BIT_MATCH] = 1'b0;
                end
                aarres_pkg::OFF_EVENT_NO_MATCH[11:2]: begin
                    if (WB_DAT_IN[0]) next_event_flag[aarres_pkg::BIT_NO_MATCH] = 1'b0;
                end
                aarres_pkg::OFF_INTERRUPT_SET[11:2]: next_int_mask = int_mask | WB_DAT_IN[2:0]; // [RULE_11]
                aarres_pkg::OFF_INTERRUPT_DISABLE[11:2]: next_int_mask = int_mask & ~WB_DAT_IN[2:0]; // [RULE_01]
                aarres_pkg::OFF_UNIT_ENABLE[11:2]: next_unit_enable = WB_DAT_IN[1:0]; // [RULE_03]
                aarres_pkg::OFF_KEY_COUNT[11:2]: next_key_count = WB_DAT_IN[4:0]; // [RULE_04]
                aarres_pkg::OFF_KEY_TABLE_POINTER[11:2]: next_key_table_pointer = WB_DAT_IN; // [RULE_05]
                aarres_pkg::OFF_TARGET_ADDRESS_POINTER[11:2]: next_target_address_pointer = WB_DAT_IN; // [RULE_06]
                aarres_pkg::OFF_SCRATCH_AREA_POINTER[11:2]: next_scratch_area_pointer = WB_DAT_IN;
                default: ;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        if (done_pulse) next_event_flag[aarres_pkg::BIT_DONE] = 1'b1; // [RULE_10]
        if (match_pulse) next_event_flag[aarres_pkg::BIT_MATCH] = 1'b1; // [RULE_10]
        if (no_match_pulse) next_event_flag[aarres_pkg::BIT_NO_MATCH] = 1'b1; // [RULE_10]
        if (match_pulse) next_status = key_idx; // [RULE_02] [RULE_12]
    end

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
            event_flag <= 3'h0;
            int_mask <= aarres_pkg::INT_MASK_RESET;
            status <= aarres_pkg::STATUS_RESET;
            unit_enable <= aarres_pkg::UNIT_ENABLE_OFF;
            key_count <= aarres_pkg::KEY_COUNT_RESET;
            key_table_pointer <= aarres_pkg::POINTER_RESET;
            target_address_pointer <= aarres_pkg::POINTER_RESET;
            scratch_area_pointer <= aarres_pkg::POINTER_RESET;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
            event_flag <= next_event_flag;
            int_mask <= next_int_mask;
            status <= next_status;
            unit_enable <= next_unit_enable;
            key_count <= next_key_count;
            key_table_pointer <= next_key_table_pointer;
            target_address_pointer <= next_target_address_pointer;
            scratch_area_pointer <= next_scratch_area_pointer;
        end
    end

    assign WB_ACK_OUT = ack;
    assign WB_DAT_OUT = rdata;
    assign IRQ_OUT = |(event_flag & int_mask);
    assign MEM_REQ_OUT = '{req: mem_req, addr: mem_addr};
endmodule : aarres_top
`default_nettype wire

/* File: verification/aarres_mem_model.sv */
// Memory partner for key and address reads
`timescale 1ns/1ps
`default_nettype none
module aarres_mem_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire aarres_pkg::aarres_mem_req_t req_in,
    output aarres_pkg::aarres_mem_rsp_t rsp_out,
    output logic [31:0] n_words_out
);
    logic [31:0] mem [0:255];
    logic [31:0] last, next_last, next_n_words;
    logic [1:0] wait_cnt, next_wait_cnt;
    // Idle data is the inverse of the last word
    always_comb begin
        rsp_out.ack = req_in.req & (wait_cnt == 2'h0);
        rsp_out.rdata = rsp_out.ack ? mem[req_in.addr[9:2]] : ~last;
        next_last = last;
        next_n_words = n_words_out;
        next_wait_cnt = (wait_cnt != 2'h0) ? wait_cnt - 2'h1 : 2'h0;
        if (rsp_out.ack) begin
            next_last = rsp_out.rdata;
            next_n_words = n_words_out + 32'h1;
            next_wait_cnt = slow_in ? (req_in.addr[3:2] ^ 2'h1) : 2'h0;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last <= 32'h0;
            n_words_out <= 32'h0;
            wait_cnt <= 2'h0;
        end else begin
            last <= next_last;
            n_words_out <= next_n_words;
            wait_cnt <= next_wait_cnt;
        end
    end
endmodule : aarres_mem_model
`default_nettype wire

/* File: verification/aarres_top_chk.sv */
// Port checker for the address resolver
`timescale 1ns/1ps
`default_nettype none
module aarres_chk #(
    parameter int MAX_KEYS = 16
) (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [11:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire logic IRQ_OUT,
    input wire aarres_pkg::aarres_mem_req_t MEM_REQ_OUT,
    input wire aarres_pkg::aarres_mem_rsp_t MEM_RSP_IN
);
    logic take, wr, rd;
    logic [1:0] en_sh, next_en_sh;
    logic [31:0] tgt_sh, next_tgt_sh;
    assign take = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    assign wr = take & WB_WE_IN & WB_SEL_IN[0];
    assign rd = take & ~WB_WE_IN;
    // Software's view of enable and target pointer
    always_comb begin
        next_en_sh = (wr && WB_ADR_IN == 12'h500) ? WB_DAT_IN[1:0] : en_sh;
        next_tgt_sh = (wr && WB_ADR_IN == 12'h510) ? WB_DAT_IN : tgt_sh;
    end
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            en_sh <= 2'h0;
            tgt_sh <= 32'h0;
        end else begin
            en_sh <= next_en_sh;
            tgt_sh <= next_tgt_sh;
        end
    end
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_latency; take |=> WB_ACK_OUT; endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("no ack");
    property p_dat_idle; !WB_ACK_OUT |-> WB_DAT_OUT == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    property p_enable_rd; rd && WB_ADR_IN == 12'h500 |=> WB_DAT_OUT[1:0] == en_sh; endproperty
    a_enable_rd: assert property (p_enable_rd) else $error("enable read");
    property p_tgt_rd; rd && WB_ADR_IN == 12'h510 |=> WB_DAT_OUT == tgt_sh; endproperty
    a_tgt_rd: assert property (p_tgt_rd) else $error("target read");
    property p_begin_fetch;
        wr && WB_ADR_IN == 12'h000 && WB_DAT_IN[0] && en_sh == 2'h3 && !MEM_REQ_OUT.req
        |=> MEM_REQ_OUT.req && MEM_REQ_OUT.addr == tgt_sh;
    endproperty
    a_begin_fetch: assert property (p_begin_fetch) else $error("no target fetch");
    property p_off_idle; wr && WB_ADR_IN == 12'h000 && WB_DAT_IN[0] && en_sh != 2'h3 |=> !MEM_REQ_OUT.req [*8]; endproperty
    a_off_idle: assert property (p_off_idle) else $error("fetch while disabled");
    property p_mask_off; wr && WB_ADR_IN == 12'h308 && WB_DAT_IN[2:0] == 3'h7 |=> !IRQ_OUT; endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq not masked");
    property p_mem_hold; MEM_REQ_OUT.req && !MEM_RSP_IN.ack |=> MEM_REQ_OUT.req && $stable(MEM_REQ_OUT.addr); endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("req dropped");
    property p_mem_step; MEM_REQ_OUT.req && MEM_RSP_IN.ack |=> MEM_REQ_OUT.addr == $past(MEM_REQ_OUT.addr) + 32'h4; endproperty
    a_mem_step: assert property (p_mem_step) else $error("addr step");
    property p_halt; wr && WB_ADR_IN == 12'h008 && WB_DAT_IN[0] |-> ##[1:4] !MEM_REQ_OUT.req; endproperty
    a_halt: assert property (p_halt) else $error("halt ignored");
endmodule : aarres_chk
bind aarres_top aarres_chk #(.MAX_KEYS(MAX_KEYS)) u_aarres_chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
    .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
    .IRQ_OUT(IRQ_OUT), .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_RSP_IN(MEM_RSP_IN));
`default_nettype wire

/* File: verification/tb.sv */
// Bench for the address resolver
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {string name; logic [31:0] exp;} aarres_exp_t;
    localparam logic [31:0] TGT = 32'h00000008;
    localparam logic [31:0] KTAB = 32'h00000100;
    logic MCLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0, ack, irq;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, n_words, w;
    logic [31:0] seed = 32'hb5e33678;
    logic [3:0] last_idx = 4'h0;
    logic [11:0] ra [0:8] = '{12'h308, 12'h400, 12'h500, 12'h504, 12'h508, 12'h510, 12'h514, 12'h100, 12'h7fc};
    aarres_pkg::aarres_mem_req_t mreq;
    aarres_pkg::aarres_mem_rsp_t mrsp;
    aarres_exp_t expq[$];
    int fails = 0;
    int n_tests = 0;
    always #2.5 MCLK_IN = ~MCLK_IN;
    aarres_top #(.MAX_KEYS(16)) u_aarres_top (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .IRQ_OUT(irq), .MEM_REQ_OUT(mreq), .MEM_RSP_IN(mrsp));
    aarres_mem_model u_aarres_mem_model (.clk_in(MCLK_IN), .rst_n_in(RST_N_IN), .slow_in(slow), .req_in(mreq),
        .rsp_out(mrsp), .n_words_out(n_words));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [23:0] fold(logic [23:0] acc, logic [31:0] x);
        return {acc[22:0], acc[23]} ^ x[23:0] ^ {16'h0000, x[31:24]};
    endfunction : fold
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // Held until ack is sampled
    task automatic bus(logic wn, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK_IN);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wn;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do begin
            @(posedge MCLK_IN);
            n++;
        end while (ack !== 1'b1 && n < 16);
        chk("wb_ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(logic [11:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] e, string name);
        expq.push_back('{name, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    always @(posedge MCLK_IN) begin
        aarres_exp_t e;
        if (ack === 1'b1 && we === 1'b0) begin
            if (expq.size() == 0) begin
                chk("unexpected_read", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                chk(e.name, e.exp, rdat);
            end
        end
    end
    // Key idx (and idx+1 if dup) folds to the hash
    task automatic run(int nk, int idx, bit dup, bit sl);
        logic [23:0] hash, pr, acc;
        logic [31:0] x, w0;
        int checked, cnt;
        x = xs();
        hash = x[23:0];
        x = xs();
        pr = x[23:0];
        u_aarres_mem_model.mem[TGT[9:2]] = {pr[7:0], hash};
        u_aarres_mem_model.mem[TGT[9:2] + 8'h1] = {16'h0000, pr[23:8]};
        for (int i = 0; i < 16; i++) begin
            acc = pr;
            for (int j = 0; j < 3; j++) begin
                x = xs();
                u_aarres_mem_model.mem[KTAB[9:2] + 8'(4 * i + j)] = x;
                acc = fold(acc, x);
            end
            x = {8'h00, hash ^ {acc[22:0], acc[23]}};
            if (!(i == idx || (dup && i == idx + 1))) x[0] = ~x[0];
            u_aarres_mem_model.mem[KTAB[9:2] + 8'(4 * i + 3)] = x;
        end
        slow <= sl;
        wr(12'h504, 32'(nk));
        wr(12'h500, 32'h3);
        wr(12'h304, 32'h7);
        w0 = n_words;
        wr(12'h000, 32'h1);
        cnt = 0;
        while (irq !== 1'b1 && cnt < 25000) begin
            @(posedge MCLK_IN);
            cnt++;
        end
        checked = (idx >= 0) ? idx + 1 : nk;
        chk("resolve_time", 32'h1, {31'h0, cnt >= 192 + 1175 * checked && cnt <= 264 + 1175 * checked});
        chk("words_fetched", 32'(2 + 4 * checked), n_words - w0);
        rd(12'h100, 32'h1, "event_done");
        rd(12'h104, {31'h0, idx >= 0}, "event_match");
        rd(12'h108, {31'h0, idx < 0}, "event_no_match");
        if (idx >= 0) last_idx = 4'(idx);
        rd(12'h400, {28'h0, last_idx}, "status");
        wr(12'h308, 32'h7);
        @(posedge MCLK_IN);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(12'h304, 32'h7);
        @(posedge MCLK_IN);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        for (int k = 0; k < 3; k++) wr(12'h100 + 12'(4 * k), 32'h1);
        @(posedge MCLK_IN);
        chk("irq_cleared", 32'h0, {31'h0, irq});
    endtask : run
    initial begin
        for (int i = 0; i < 256; i++) u_aarres_mem_model.mem[i] = xs();
        repeat (2) @(posedge MCLK_IN);
        RST_N_IN <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ra[i], (i == 3) ? 32'h1 : 32'h0, "reset_value");
        for (int i = 0; i < 2; i++) begin
            w = xs();
            wr(12'h508 + 12'(8 * i), w);
            rd(12'h508 + 12'(8 * i), w, "pointer_rw");
        end
        wr(12'h508, KTAB);
        wr(12'h510, TGT);
        wr(12'h514, 32'h000003f0);
        rd(12'h514, 32'h000003f0, "scratch_ptr");
        wr(12'h304, 32'h7);
        rd(12'h308, 32'h7, "int_mask");
        wr(12'h308, 32'h2);
        rd(12'h304, 32'h5, "int_mask");
        wr(12'h308, 32'h0);
        rd(12'h308, 32'h5, "int_mask");
        wr(12'h308, 32'h7);
        rd(12'h308, 32'h0, "int_mask");
        w = n_words;
        wr(12'h000, 32'h1);
        repeat (40) @(posedge MCLK_IN);
        chk("idle_when_off", w, n_words);
        run(8, -1, 1'b0, 1'b0);
        w = xs();
        run(16, int'(w[3:0]) % 14, 1'b1, 1'b1);
        run(1, 0, 1'b0, 1'b0);
        run(16, 15, 1'b0, 1'b0);
        rd(12'h504, 32'h10, "key_count");
        wr(12'h000, 32'h1);
        repeat (300) @(posedge MCLK_IN);
        wr(12'h008, 32'h1);
        repeat (3000) @(posedge MCLK_IN);
        rd(12'h100, 32'h0, "done_after_halt");
        rd(12'h500, 32'h3, "unit_enable");
        wr(12'h500, 32'h0);
        rd(12'h500, 32'h0, "unit_enable");
        end_sim();
    end
    // Runs take about 35k to 50k cycles, by the random match index
    initial begin
        repeat (90000) @(posedge MCLK_IN);
        fails++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
